/* File: eas_front.sv */
// Two-wire slave front end: start/stop detection, address match, word
// address capture and acknowledge drive.
// Assumes the bus master meets the bus timing and the array logic
// supplies the busy level and read bits on the system clock.
`include "eas_params.svh"
`default_nettype none

module eas_front #(
    parameter int ADDR_BITS = 14,
    parameter logic [3:0] TYPE_CODE = 4'h5 // Arbitrary value.
) (
    // System clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Bus pins; the clock pin is input only.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Configuration and status from the array logic.
    input wire logic [2:0] slave_address_config_register_i,
    input wire logic prog_busy_i,
    input wire logic rd_bit_i,
    // Decoded command.
    output eas_pkg::eas_cmd_t cmd_o,
    output logic cmd_valid_o,
    output logic wr_bit_valid_o,
    output logic wr_bit_o,
    output logic rd_bit_req_o,
    output logic stop_o,
    output logic [`EAS_PAGE_BITS-1:0] page_byte_o
);
    import eas_pkg::*;

    function automatic logic addr_match(input logic [7:0] b,
                                        input logic [2:0] hw,
                                        input logic [3:0] tc);
        addr_match = (b[`EAS_TYPE_MSB:`EAS_TYPE_LSB] == tc) &&
                     (b[`EAS_HW_MSB:`EAS_HW_LSB] == hw);
    endfunction : addr_match

    ////////////////////////////////////////////////////////////////////
    // Synchronisers and glitch filter.
    localparam int FILT = (`EAS_FILT_CYC < 1) ? 1 : `EAS_FILT_CYC;
    localparam int FW = $clog2(FILT + 1);
    logic [1:0] scl_sync_ff, sda_sync_ff;
    logic scl_ff, sda_ff, scl_q_ff, sda_q_ff;
    logic [FW-1:0] scl_cnt_ff, sda_cnt_ff;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
        end
    end

    // glitch filter
    // A level must hold FILT clocks; shorter spikes are swallowed.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            scl_cnt_ff <= '0;
            sda_cnt_ff <= '0;
        end else begin
            if (scl_sync_ff[1] == scl_ff) begin
                scl_cnt_ff <= '0;
            end else if (scl_cnt_ff == FW'(FILT - 1)) begin
                scl_ff <= scl_sync_ff[1];
                scl_cnt_ff <= '0;
            end else begin
                scl_cnt_ff <= scl_cnt_ff + FW'(1);
            end
            if (sda_sync_ff[1] == sda_ff) begin
                sda_cnt_ff <= '0;
            end else if (sda_cnt_ff == FW'(FILT - 1)) begin
                sda_ff <= sda_sync_ff[1];
                sda_cnt_ff <= '0;
            end else begin
                sda_cnt_ff <= sda_cnt_ff + FW'(1);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_ff;
            sda_q_ff <= sda_ff;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_ff & ~scl_q_ff;
    assign scl_fall = ~scl_ff & scl_q_ff;
    assign start_det = scl_ff & scl_q_ff & sda_q_ff & ~sda_ff;
    assign stop_det = scl_ff & scl_q_ff & ~sda_q_ff & sda_ff;

    ////////////////////////////////////////////////////////////////////
    // Bit and byte framing.
    eas_state_t state_ff, nxt_state;
    logic [7:0] shift_ff;
    logic [3:0] bit_cnt_ff;
    logic ack_slot, byte_done, read_ff, cfg_ff, ack_drive_ff;
    logic [ADDR_BITS-1:0] addr_ff;
    logic [7:0] next_byte;

    assign ack_slot = (bit_cnt_ff == 4'h8);
    assign next_byte = {shift_ff[6:0], sda_ff};
    assign byte_done = scl_rise && (bit_cnt_ff == 4'h7);

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || start_det || stop_det) begin
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
        end else if (scl_fall && bit_cnt_ff == 4'h9) begin
            bit_cnt_ff <= 4'h0;
        end else if (scl_rise && bit_cnt_ff != 4'h9) begin
            // The ninth rise is the acknowledge pulse; it is counted only.
            if (!ack_slot) begin
                shift_ff <= next_byte;
            end
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command state machine.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            EAS_IDLE: nxt_state = EAS_IDLE;
            EAS_DEV: begin
                if (byte_done) begin
                    if (!addr_match(next_byte,
                            slave_address_config_register_i, TYPE_CODE) ||
                        prog_busy_i) begin
                        nxt_state = EAS_IDLE;
                    end else if (next_byte[`EAS_DIR_BIT]) begin
                        nxt_state = EAS_DATA;
                    end else begin
                        nxt_state = EAS_WA1;
                    end
                end
            end
            EAS_WA1: if (byte_done) nxt_state = EAS_WA2;
            EAS_WA2: if (byte_done) nxt_state = EAS_DATA;
            EAS_DATA: begin
                if (read_ff && scl_rise && ack_slot && sda_ff) begin
                    nxt_state = EAS_WAIT;
                end
            end
            EAS_WAIT: nxt_state = EAS_WAIT;
            default: nxt_state = EAS_IDLE;
        endcase
        if (start_det) begin
            nxt_state = EAS_DEV;
        end else if (stop_det) begin
            nxt_state = EAS_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_ff <= EAS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            read_ff <= 1'b0;
            cfg_ff <= 1'b0;
            addr_ff <= '0;
        end else if (byte_done) begin
            case (state_ff)
                EAS_DEV: read_ff <= next_byte[`EAS_DIR_BIT];
                EAS_WA1: begin
                    cfg_ff <= next_byte[`EAS_REGION_BIT];
                    addr_ff[ADDR_BITS-1:8] <= next_byte[ADDR_BITS-9:0];
                end
                EAS_WA2: if (!cfg_ff) addr_ff[7:0] <= next_byte;
                default: addr_ff <= addr_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Acknowledge and read drive.
    logic ack_need, drive_low_ff;
    assign ack_need = byte_done &&
        ((state_ff == EAS_DEV && nxt_state != EAS_IDLE) ||
         state_ff == EAS_WA1 || state_ff == EAS_WA2 ||
         (state_ff == EAS_DATA && !read_ff));

    // hold low whole ack
    // Changes follow a clock fall so the line is stable while high.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || start_det || stop_det) begin
            ack_drive_ff <= 1'b0;
            drive_low_ff <= 1'b0;
        end else begin
            if (ack_need) begin
                ack_drive_ff <= 1'b1;
            end else if (scl_fall && bit_cnt_ff == 4'h9) begin
                ack_drive_ff <= 1'b0;
            end
            if (scl_fall) begin
                if (ack_slot) begin
                    drive_low_ff <= ack_drive_ff;
                end else if (state_ff == EAS_DATA && read_ff) begin
                    drive_low_ff <= ~rd_bit_i;
                end else begin
                    drive_low_ff <= 1'b0;
                end
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~drive_low_ff;

    ////////////////////////////////////////////////////////////////////
    // Command outputs.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            cmd_valid_o <= 1'b0;
            wr_bit_valid_o <= 1'b0;
            wr_bit_o <= 1'b0;
            rd_bit_req_o <= 1'b0;
            stop_o <= 1'b0;
        end else begin
            cmd_valid_o <= byte_done && ((state_ff == EAS_WA2) ||
                (state_ff == EAS_DEV && nxt_state == EAS_DATA));
            wr_bit_valid_o <= scl_rise && !ack_slot &&
                              state_ff == EAS_DATA && !read_ff;
            wr_bit_o <= sda_ff;
            rd_bit_req_o <= scl_fall && state_ff == EAS_DATA && read_ff;
            stop_o <= stop_det;
        end
    end

    assign cmd_o = '{read: read_ff, cfg: cfg_ff, addr: 14'(addr_ff)};
    assign page_byte_o = addr_ff[`EAS_PAGE_BITS-1:0];

endmodule : eas_front

`default_nettype wire

/* File: eas_front_sva.sv */
// Checker for the address front end ports.
// Assumes one clock domain with a synchronous active-low reset.
`default_nettype none
module eas_front_sva #(
    parameter int ADDR_BITS = 14,
    parameter logic [3:0] TYPE_CODE = 4'h5 // Arbitrary value.
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Watched ports.
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic prog_busy_i,
    input wire eas_pkg::eas_cmd_t cmd_o,
    input wire logic cmd_valid_o,
    input wire logic stop_o,
    input wire logic [4:0] page_byte_o
);
    import eas_pkg::*;
    logic [6:0] busy_cnt_ff;
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || !prog_busy_i) begin
            busy_cnt_ff <= 7'h0;
        end else if (busy_cnt_ff != 7'h40) begin
            busy_cnt_ff <= busy_cnt_ff + 7'h1;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    a_pin_pull_down: assert property
        (sda_o == 1'b0) else $error("data value not zero");
    a_ack_held: assert property
        ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*8]) else $error("short pull");
    a_busy_no_ack: assert property
        (busy_cnt_ff == 7'h40 |-> sda_oe_n_o) else $error("ack while busy");
    a_cmd_not_busy: assert property
        (cmd_valid_o |-> !prog_busy_i) else $error("command while busy");
    a_page_field: assert property
        (page_byte_o == cmd_o.addr[4:0]) else $error("page field wrong");
    a_cmd_pulse: assert property
        (cmd_valid_o |=> !cmd_valid_o) else $error("command not a pulse");
    a_stop_level: assert property
        (stop_o |-> scl_i && sda_i) else $error("stop without high lines");
    a_stop_release: assert property
        (stop_o |-> ##1 sda_oe_n_o [*4]) else $error("pin held after stop");
    c_read: cover property (cmd_valid_o && cmd_o.read);
    c_cfg: cover property (cmd_valid_o && cmd_o.cfg);
    c_stop: cover property (stop_o);
endmodule : eas_front_sva
bind eas_front eas_front_sva #(.ADDR_BITS(ADDR_BITS), .TYPE_CODE(TYPE_CODE))
    eas_front_sva_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .prog_busy_i(prog_busy_i), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o),
    .stop_o(stop_o), .page_byte_o(page_byte_o));
`default_nettype wire

/* File: eas_master.sv */
// Bus master model: clock, Start, Stop and bit transfers.
// Assumes mclk at 200 MHz; one bit spans 27 mclk periods.
`default_nettype none
module eas_master (
    // Clock and device pin.
    input wire logic mclk,
    input wire logic dev_sda,
    input wire logic dev_oe_n,
    // Bus wires.
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b1;
    initial scl = 1'b1;
    assign sda = drv & (dev_oe_n | dev_sda);
    task automatic step(input logic d, input logic c, input int n);
        drv <= d;
        scl <= c;
        repeat (n) @(posedge mclk);
    endtask : step
    task automatic start();
        step(1'b1, scl, 8);
        step(1'b1, 1'b1, 6);
        step(1'b0, 1'b1, 5);
        step(1'b0, 1'b0, 6);
    endtask : start
    // data moves in low phase
    // Sampled at the end of high, as the device sees edges late.
    // The low phase outlasts the device's filter delay, so its own
    // acknowledge lands before the next rise and never looks like a Start.
    task automatic bit_io(input logic b, output logic r);
        step(b, 1'b0, 10);
        step(b, 1'b1, 11);
        r = sda;
        step(b, 1'b0, 6);
    endtask : bit_io
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                           output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(1'b1, ack);
    endtask : byte_io
    task automatic recover();
        logic r;
        for (int i = 0; i < 9; i++) begin
            bit_io(1'b1, r);
            if (r) break;
        end
    endtask : recover
    task automatic stop();
        step(1'b0, 1'b0, 8);
        step(1'b0, 1'b1, 6);
        step(1'b1, 1'b1, 40);
    endtask : stop
endmodule : eas_master
`default_nettype wire

/* File: eas_params.svh */
// Constants for the serial EEPROM slave address front end.
// Assumes a single 200 MHz system clock and a bus clock well below it.
`ifndef EAS_PARAMS_SVH
`define EAS_PARAMS_SVH

// Device type code sits in the top nibble of the address byte.
`define EAS_TYPE_MSB 7
`define EAS_TYPE_LSB 4
`define EAS_HW_MSB 3
`define EAS_HW_LSB 1
`define EAS_DIR_BIT 0
// Region select in the first word address byte.
`define EAS_REGION_BIT 7
// Byte-in-page field of the captured address.
`define EAS_PAGE_BITS 5
// Glitch filter length in system clocks (spike limit 50 ns).
`define EAS_SPIKE_NS 50
`define EAS_CLK_MHZ 200
`define EAS_FILT_CYC ((`EAS_SPIKE_NS * `EAS_CLK_MHZ + 999) / 1000)
// Reset value of the hardware slave address.
`define EAS_HW_ADDR_RST 3'h0

`endif

/* File: eas_pkg.sv */
// Types shared by the address front end.
// Assumes the params header is included by the design.
`default_nettype none

package eas_pkg;

    typedef enum logic [2:0] {
        EAS_IDLE = 3'b000,
        EAS_DEV = 3'b001,
        EAS_WA1 = 3'b011,
        EAS_WA2 = 3'b010,
        EAS_DATA = 3'b110,
        EAS_WAIT = 3'b111
    } eas_state_t;

    // Decoded command handed to the array or configuration logic.
    typedef struct packed {
        logic read;
        logic cfg;
        logic [13:0] addr;
    } eas_cmd_t;

    // Open-drain pin: level seen, level driven, enable low when driving.
    typedef struct packed {
        logic in;
        logic out;
        logic oe_n;
    } eas_pin_t;

endpackage : eas_pkg

`default_nettype wire

/* File: test_eas_front.sv */
// Bench: writes and reads on every hardware address, then refusals.
// Assumes the master model and the bound checker are compiled first.
`default_nettype none
module test_eas_front;
    timeunit 1ns;
    timeprecision 1ps;
    import eas_pkg::*;
    localparam logic [3:0] TC = 4'h6; // Arbitrary type code.
    logic mclk = 1'b0, rst_n = 1'b0, busy = 1'b0, rd_bit = 1'b0;
    logic scl, sda, sda_o, oe_n, cmd_valid, ack;
    logic [2:0] hw = 3'h0;
    logic [7:0] q, w1, w2;
    logic [31:0] n;
    logic [31:0] notes[$];
    eas_cmd_t cmd;
    int failures = 0, checks = 0, cyc = 0;
    always #2.5 mclk = ~mclk;
    eas_front #(.TYPE_CODE(TC)) eas_front_i (.mclk_i(mclk),
        .reset_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n_o(oe_n), .slave_address_config_register_i(hw),
        .prog_busy_i(busy), .rd_bit_i(rd_bit), .cmd_o(cmd),
        .cmd_valid_o(cmd_valid), .wr_bit_valid_o(), .wr_bit_o(),
        .rd_bit_req_o(), .stop_o(), .page_byte_o());
    eas_master eas_master_i (.mclk(mclk), .dev_sda(sda_o), .dev_oe_n(oe_n),
        .scl(scl), .sda(sda));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    // Notes hold a compare mask over the expected command.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            print_verdict();
        end
        if (cmd_valid === 1'b1) begin
            n = (notes.size() > 0) ? notes.pop_front() : {16'hffff, ~cmd};
            check(cmd & n[31:16], n[15:0]);
        end
    end
    task automatic addr(input logic [7:0] a, input logic ea);
        eas_master_i.start();
        eas_master_i.byte_io(a, q, ack);
        check(16'(ack), 16'(ea));
    endtask : addr
    task automatic wr();
        w1 = 8'($urandom);
        w2 = 8'($urandom);
        notes.push_back(w1[7] ? 32'hc000_4000 : {16'hffff, 2'b0, w1[5:0], w2});
        addr({TC, hw, 1'b0}, 1'b0);
        eas_master_i.byte_io(w1, q, ack);
        check(16'(ack), 16'h0);
        eas_master_i.byte_io(w2, q, ack);
        check(16'(ack), 16'h0);
        eas_master_i.byte_io(8'($urandom), q, ack);
        check(16'(ack), 16'h0);
        eas_master_i.stop();
    endtask : wr
    initial begin
        void'($urandom(32'h350fc187));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 16; i++) begin
            hw <= 3'(i >> 1);
            rd_bit <= 1'($urandom);
            @(posedge mclk);
            if (i % 2 == 1) begin
                notes.push_back(32'h8000_8000);
                addr({TC, hw, 1'b1}, 1'b0);
                eas_master_i.byte_io(8'hff, q, ack);
                check(16'(q), {8'h0, {8{rd_bit}}});
                eas_master_i.stop();
            end else begin
                wr();
            end
        end
        addr({~TC, hw, 1'b0}, 1'b1);
        eas_master_i.stop();
        addr({TC, ~hw, 1'b0}, 1'b1);
        eas_master_i.stop();
        busy <= 1'b1;
        addr({TC, hw, 1'b0}, 1'b1);
        eas_master_i.stop();
        busy <= 1'b0;
        // A Start in mid-byte must restart matching.
        eas_master_i.start();
        repeat (4) eas_master_i.bit_io(1'b0, ack);
        eas_master_i.recover();
        wr();
        print_verdict();
    end
endmodule : test_eas_front
`default_nettype wire
